// ==== rtl/gdcfg_pkg.sv ====
/*
  Constants shared by the gate driver configuration register block.
  Assumes the frame decoder hands over 5-bit addresses and 10-bit data.
*/
package gdcfg_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [4:0] GDCFG_ADDR_GWD = 5'h07;
  localparam logic [4:0] GDCFG_ADDR_DESAT = 5'h08;
  // ==========================================================
  // Field positions in the 10-bit data word
  localparam int GDCFG_SETPT_LSB = 7;
  localparam int GDCFG_LINK_WATCHDOG_TIMEOUT_LSB = 4;
  localparam int GDCFG_DELAY_LSB = 0;
  localparam int GDCFG_DESAT_LSB = 0;
  // ==========================================================
  // Reset and substitute values
  localparam logic [2:0] GDCFG_SETPT_RST = 3'h1;
  localparam logic [1:0] GDCFG_LINK_WATCHDOG_TIMEOUT_RST = 2'h3;
  localparam logic [3:0] GDCFG_DELAY_RST = 4'hA;
  localparam logic [3:0] GDCFG_DELAY_SUBST = 4'hA;
  localparam logic [3:0] GDCFG_DESAT_RST = 4'hA;
  // ==========================================================
  // Decode scales
  localparam int GDCFG_SETPT_BASE_MV = 14000;
  localparam int GDCFG_SETPT_STEP_MV = 1000;
  localparam int GDCFG_DELAY_STEP_NS = 400;
  localparam int GDCFG_DELAY_WIDE_NS = 800;
  localparam int GDCFG_DELAY_WIDE_OFS = 5;
  localparam int GDCFG_DELAY_FINE_MAX = 10;
  localparam int GDCFG_DESAT_BASE_MV = 1000;
  localparam int GDCFG_DESAT_STEP_MV = 500;
  localparam int GDCFG_DESAT_FINE_MAX = 12;
  localparam int GDCFG_DESAT_WIDE_OFS = 5;
  localparam int GDCFG_DESAT_WIDE_MV = 1000;
  localparam logic [11:0] GDCFG_LINK_WATCHDOG_TIMEOUT_US0 = 12'h104;
  localparam logic [11:0] GDCFG_LINK_WATCHDOG_TIMEOUT_US1 = 12'h1F4;
  localparam logic [11:0] GDCFG_LINK_WATCHDOG_TIMEOUT_US2 = 12'h3E8;
  localparam logic [11:0] GDCFG_LINK_WATCHDOG_TIMEOUT_US3 = 12'h7D0;
endpackage

// ==== rtl/gdcfg_cfg_if.sv ====
/*
  Carrier of the raw configuration fields from the register file to the
  decoder. Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface gdcfg_cfg_if;
  logic [2:0] setpoint;
  logic [1:0] link_watchdog_timeout;
  logic [3:0] delay;
  logic [3:0] desat;
  logic time_scale;
  modport src (output setpoint, output link_watchdog_timeout, output delay, output desat,
    output time_scale);
  modport dst (input setpoint, input link_watchdog_timeout, input delay, input desat,
    input time_scale);
endinterface

// ==== rtl/gdcfg_decode.sv ====
/*
  Turns raw configuration codes into physical targets, registered.
  Assumes fields arrive from the register file on the same clock.
*/
`timescale 1ns/1ps
module gdcfg_decode (
  input wire logic clk_in,
  input wire logic arst_n_in,
  gdcfg_cfg_if.dst cfg,
  output logic [15:0] setpoint_mv_out,
  output logic [11:0] link_watchdog_timeout_us_out,
  output logic [13:0] delay_ns_out,
  output logic [13:0] desat_mv_out
);
  import gdcfg_pkg::*;

  typedef struct packed {
    logic [15:0] setpt;
    logic [11:0] link_watchdog_timeout;
    logic [13:0] delay;
    logic [13:0] desat;
  } gdcfg_dec_t;

  gdcfg_dec_t st_ff;
  gdcfg_dec_t nxt_st;

  // ==========================================================
  // Decode functions
  function automatic logic [13:0] delay_ns(input logic [3:0] c,
                                           input logic half);
    int v;
    v = 0;
    if (c <= 4'(GDCFG_DELAY_FINE_MAX)) begin
      v = int'(c) * GDCFG_DELAY_STEP_NS;
    end else begin
      v = (int'(c) - GDCFG_DELAY_WIDE_OFS) * GDCFG_DELAY_WIDE_NS;
    end
    if (half) begin
      v = (c < 4'h2) ? 0 : v / 2;
    end
    return v[13:0];
  endfunction

  function automatic logic [13:0] desat_mv(input logic [3:0] c);
    int v;
    v = 0;
    if (c <= 4'(GDCFG_DESAT_FINE_MAX)) begin
      v = GDCFG_DESAT_BASE_MV + int'(c) * GDCFG_DESAT_STEP_MV;
    end else begin
      v = (int'(c) - GDCFG_DESAT_WIDE_OFS) * GDCFG_DESAT_WIDE_MV;
    end
    return v[13:0];
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    int sp;
    sp = GDCFG_SETPT_BASE_MV + int'(cfg.setpoint) * GDCFG_SETPT_STEP_MV;
    nxt_st = st_ff;
    // Code 0 has no target; report zero so the regulator can refuse it
    nxt_st.setpt = (cfg.setpoint == 3'h0) ? 16'h0000 : sp[15:0];
    unique case (cfg.link_watchdog_timeout)
      2'h0: nxt_st.link_watchdog_timeout = GDCFG_LINK_WATCHDOG_TIMEOUT_US0;
      2'h1: nxt_st.link_watchdog_timeout = GDCFG_LINK_WATCHDOG_TIMEOUT_US1;
      2'h2: nxt_st.link_watchdog_timeout = GDCFG_LINK_WATCHDOG_TIMEOUT_US2;
      2'h3: nxt_st.link_watchdog_timeout = GDCFG_LINK_WATCHDOG_TIMEOUT_US3;
    endcase
    nxt_st.delay = delay_ns(cfg.delay, cfg.time_scale);
    nxt_st.desat = desat_mv(cfg.desat);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign setpoint_mv_out = st_ff.setpt;
  assign link_watchdog_timeout_us_out = st_ff.link_watchdog_timeout;
  assign delay_ns_out = st_ff.delay;
  assign desat_mv_out = st_ff.desat;
endmodule

// ==== rtl/gdcfg_regs.sv ====
/*
  Two configuration registers of a gate driver: gate supply setpoint,
  link watchdog timeout and feedback check delay, plus desaturation
  threshold. Assumes a frame decoder on the same clock presents checked
  accesses, and that mode logic supplies the setup state and timer scaling.
*/
//
// Contract
// - Address 0x07 holds a 3-bit setpoint, 2-bit watchdog and 4-bit delay.
// - Setpoint writes are taken at any time, setup state or not.
// - Watchdog, delay and threshold writes take effect only in setup state.
// - Setpoint codes 1..7 mean 15 V..21 V in 1 V steps; reset gives code 1.
// - Watchdog codes 0..3 mean 260, 500, 1000, 2000 us; reset gives code 3.
// - Unscaled delay code n is n*400 ns up to 10, then 800 ns steps to 8000.
// - Scaled delays are halved, codes 0 and 1 unused; reset gives code 10.
// - Any change of the timer scaling bit forces the delay code to 10.
// - Threshold sits in the low 4 bits of 0x08; upper 6 bits read zero.
// - Threshold codes 0..12 mean 1 V..7 V by 0.5 V, then 8, 9, 10 V.
`timescale 1ns/1ps
module gdcfg_regs (
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  input wire logic [4:0] ADDR_IN,
  input wire logic [9:0] WR_DATA_IN,
  input wire logic SETUP_MODE_IN,
  input wire logic TIME_SCALE_IN,
  output logic [9:0] RD_DATA_OUT,
  output logic RD_VALID_OUT,
  output logic [2:0] SETPOINT_CODE_OUT,
  output logic [1:0] LINK_WATCHDOG_TIMEOUT_CODE_OUT,
  output logic [3:0] DELAY_CODE_OUT,
  output logic [3:0] DESAT_CODE_OUT,
  output logic [15:0] SETPOINT_MV_OUT,
  output logic [11:0] LINK_WATCHDOG_TIMEOUT_US_OUT,
  output logic [13:0] DELAY_NS_OUT,
  output logic [13:0] DESAT_MV_OUT
);
  import gdcfg_pkg::*;

  typedef struct packed {
    logic [2:0] setpoint;
    logic [1:0] link_watchdog_timeout;
    logic [3:0] delay;
    logic [3:0] desat;
    logic scale;
    logic [9:0] rdata;
    logic rvalid;
  } gdcfg_state_t;

  gdcfg_state_t st_ff;
  gdcfg_state_t nxt_st;
  gdcfg_cfg_if cfg_bus ();

  // ==========================================================
  // Lock map: high where normal mode refuses a write to the field
  // Watchdog and delay share a word but keep separate flags
  localparam logic LOCK_SETPT = 1'h0;
  localparam logic LOCK_LINK_WATCHDOG_TIMEOUT = 1'h1;
  localparam logic LOCK_DELAY = 1'h1;
  localparam logic LOCK_DESAT = 1'h1;

  // ==========================================================
  // Address decode
  // Read mux and write strobes share these so the map cannot drift
  function automatic logic hit_gwd(input logic [4:0] a);
    return a == GDCFG_ADDR_GWD;
  endfunction

  function automatic logic hit_desat(input logic [4:0] a);
    return a == GDCFG_ADDR_DESAT;
  endfunction

  // ==========================================================
  // Write permission
  // The setpoint is open at all times; the rest only in setup state
  function automatic logic field_open(input logic locked,
                                      input logic setup);
    return !locked || setup;
  endfunction

  // ==========================================================
  // Field extraction from a write word
  // Spare bits of the word are simply never picked up
  function automatic logic [2:0] take_setpoint(input logic [9:0] w);
    return w[GDCFG_SETPT_LSB +: 3];
  endfunction

  function automatic logic [1:0] take_link_watchdog_timeout(input logic [9:0] w);
    return w[GDCFG_LINK_WATCHDOG_TIMEOUT_LSB +: 2];
  endfunction

  function automatic logic [3:0] take_delay(input logic [9:0] w);
    return w[GDCFG_DELAY_LSB +: 4];
  endfunction

  function automatic logic [3:0] take_desat(input logic [9:0] w);
    return w[GDCFG_DESAT_LSB +: 4];
  endfunction

  // ==========================================================
  // Register images
  function automatic logic [9:0] pack_gwd(input gdcfg_state_t s);
    logic [9:0] w;
    w = 10'h000;
    // Spare bit 6 left at zero
    w[GDCFG_SETPT_LSB +: 3] = s.setpoint;
    w[GDCFG_LINK_WATCHDOG_TIMEOUT_LSB +: 2] = s.link_watchdog_timeout;
    w[GDCFG_DELAY_LSB +: 4] = s.delay;
    return w;
  endfunction

  function automatic logic [9:0] pack_desat(input gdcfg_state_t s);
    logic [9:0] w;
    w = 10'h000;
    // Upper six bits are unused and stay zero
    w[GDCFG_DESAT_LSB +: 4] = s.desat;
    return w;
  endfunction

  // Unmapped addresses read as zero rather than aliasing a register
  function automatic logic [9:0] read_word(input gdcfg_state_t s,
                                           input logic [4:0] a);
    logic [9:0] w;
    w = 10'h000;
    if (hit_gwd(a)) begin
      w = pack_gwd(s);
    end else if (hit_desat(a)) begin
      w = pack_desat(s);
    end
    return w;
  endfunction

  // ==========================================================
  // Scaling change detect
  // Level compared against the copy taken at the last edge
  function automatic logic scale_moved(input logic now_lvl,
                                       input logic was_lvl);
    return now_lvl != was_lvl;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic wr_gwd;
    logic wr_desat;
    wr_gwd = WR_EN_IN && hit_gwd(ADDR_IN);
    wr_desat = WR_EN_IN && hit_desat(ADDR_IN);
    nxt_st = st_ff;
    nxt_st.scale = TIME_SCALE_IN;
    // Setpoint may move during normal operation
    if (wr_gwd && field_open(LOCK_SETPT, SETUP_MODE_IN)) begin
      nxt_st.setpoint = take_setpoint(WR_DATA_IN);
    end
    if (wr_gwd && field_open(LOCK_LINK_WATCHDOG_TIMEOUT, SETUP_MODE_IN)) begin
      nxt_st.link_watchdog_timeout = take_link_watchdog_timeout(WR_DATA_IN);
    end
    if (wr_gwd && field_open(LOCK_DELAY, SETUP_MODE_IN)) begin
      nxt_st.delay = take_delay(WR_DATA_IN);
    end
    if (wr_desat && field_open(LOCK_DESAT, SETUP_MODE_IN)) begin
      nxt_st.desat = take_desat(WR_DATA_IN);
    end
    // Scaling change wins over a same-cycle write, so the delay never
    // lands on a code that is unused in the new scale
    if (scale_moved(TIME_SCALE_IN, st_ff.scale)) begin
      nxt_st.delay = GDCFG_DELAY_SUBST;
    end
    // A read in the same cycle as a write returns the old contents
    nxt_st.rvalid = RD_EN_IN;
    nxt_st.rdata = RD_EN_IN ? read_word(st_ff, ADDR_IN) : 10'h000;
  end

  // ==========================================================
  // State register
  // Scale resets low; a high strap at release counts as a change and
  // reloads the substitute code, which equals the reset code anyway.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      st_ff.setpoint <= GDCFG_SETPT_RST;
      st_ff.link_watchdog_timeout <= GDCFG_LINK_WATCHDOG_TIMEOUT_RST;
      st_ff.delay <= GDCFG_DELAY_RST;
      st_ff.desat <= GDCFG_DESAT_RST;
      st_ff.scale <= 1'b0;
      st_ff.rdata <= 10'h000;
      st_ff.rvalid <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Decoder
  // Decoded targets trail the codes by one cycle
  assign cfg_bus.setpoint = st_ff.setpoint;
  assign cfg_bus.link_watchdog_timeout = st_ff.link_watchdog_timeout;
  assign cfg_bus.delay = st_ff.delay;
  assign cfg_bus.desat = st_ff.desat;
  assign cfg_bus.time_scale = st_ff.scale;

  gdcfg_decode u_decode (
    .clk_in(CLOCK_IN),
    .arst_n_in(ARST_N_IN),
    .cfg(cfg_bus.dst),
    .setpoint_mv_out(SETPOINT_MV_OUT),
    .link_watchdog_timeout_us_out(LINK_WATCHDOG_TIMEOUT_US_OUT),
    .delay_ns_out(DELAY_NS_OUT),
    .desat_mv_out(DESAT_MV_OUT)
  );

  // ==========================================================
  // Outputs
  // Codes leave straight from the flops, so consumers never see a
  // half-written word
  assign RD_DATA_OUT = st_ff.rdata;
  assign RD_VALID_OUT = st_ff.rvalid;
  assign SETPOINT_CODE_OUT = st_ff.setpoint;
  assign LINK_WATCHDOG_TIMEOUT_CODE_OUT = st_ff.link_watchdog_timeout;
  assign DELAY_CODE_OUT = st_ff.delay;
  assign DESAT_CODE_OUT = st_ff.desat;
endmodule

// ==== dv/gdcfg_regs_monitor.sv ====
/*
  Assertion checker for gdcfg_regs, seeing only the top ports.
  Assumes one clock and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
module gdcfg_regs_monitor (
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  input wire logic [4:0] ADDR_IN,
  input wire logic [9:0] WR_DATA_IN,
  input wire logic SETUP_MODE_IN,
  input wire logic TIME_SCALE_IN,
  input wire logic [9:0] RD_DATA_OUT,
  input wire logic RD_VALID_OUT,
  input wire logic [2:0] SETPOINT_CODE_OUT,
  input wire logic [1:0] LINK_WATCHDOG_TIMEOUT_CODE_OUT,
  input wire logic [3:0] DELAY_CODE_OUT,
  input wire logic [3:0] DESAT_CODE_OUT,
  input wire logic [15:0] SETPOINT_MV_OUT,
  input wire logic [11:0] LINK_WATCHDOG_TIMEOUT_US_OUT,
  input wire logic [13:0] DESAT_MV_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // ====================
  // Sequences
  sequence s_wr7;
    WR_EN_IN && ADDR_IN == 5'h07;
  endsequence
  sequence s_rd8;
    RD_EN_IN && ADDR_IN == 5'h08;
  endsequence
  // ====================
  // Properties
  property p_rdv; RD_EN_IN |=> RD_VALID_OUT && !RD_DATA_OUT[6]; endproperty
  property p_hi; s_rd8 |=> RD_DATA_OUT[9:4] == 6'h00; endproperty
  property p_sp;
    s_wr7 |=> SETPOINT_CODE_OUT == $past(WR_DATA_IN[9:7]);
  endproperty
  property p_wd;
    s_wr7 ##0 SETUP_MODE_IN |=> LINK_WATCHDOG_TIMEOUT_CODE_OUT == $past(WR_DATA_IN[5:4]);
  endproperty
  // Locked watchdog and threshold fields keep their codes whatever a frame carries
  property p_lock;
    !SETUP_MODE_IN |=> $stable(LINK_WATCHDOG_TIMEOUT_CODE_OUT) && $stable(DESAT_CODE_OUT);
  endproperty
  property p_ts; $changed(TIME_SCALE_IN) |=> DELAY_CODE_OUT == 4'hA; endproperty
  property p_sp7; SETPOINT_CODE_OUT == 3'h7 |=> SETPOINT_MV_OUT == 16'h5208;
  endproperty
  property p_wd0; LINK_WATCHDOG_TIMEOUT_CODE_OUT == 2'h0 |=> LINK_WATCHDOG_TIMEOUT_US_OUT == 12'h104; endproperty
  property p_ds; DESAT_CODE_OUT == 4'hF |=> DESAT_MV_OUT == 14'h2710;
  endproperty
  a_rdv: assert property (p_rdv) else $error("read slot");
  a_hi: assert property (p_hi) else $error("upper bits");
  a_sp: assert property (p_sp) else $error("setpoint write");
  a_wd: assert property (p_wd) else $error("watchdog write");
  a_lock: assert property (p_lock) else $error("locked field");
  a_ts: assert property (p_ts) else $error("scale default");
  a_sp7: assert property (p_sp7) else $error("setpoint mv");
  a_wd0: assert property (p_wd0) else $error("watchdog us");
  a_ds: assert property (p_ds) else $error("threshold mv");
endmodule
bind gdcfg_regs gdcfg_regs_monitor mon (.CLOCK_IN, .ARST_N_IN, .WR_EN_IN,
  .RD_EN_IN, .ADDR_IN, .WR_DATA_IN, .SETUP_MODE_IN, .TIME_SCALE_IN,
  .RD_DATA_OUT, .RD_VALID_OUT, .SETPOINT_CODE_OUT, .LINK_WATCHDOG_TIMEOUT_CODE_OUT,
  .DELAY_CODE_OUT, .DESAT_CODE_OUT, .SETPOINT_MV_OUT, .LINK_WATCHDOG_TIMEOUT_US_OUT,
  .DESAT_MV_OUT);

// ==== dv/gdcfg_regs_tb.sv ====
/*
  Self-checking bench for gdcfg_regs.
  Assumes the package and design are compiled first.
*/
`timescale 1ns/1ps
module gdcfg_regs_tb;
  logic CLOCK_IN = 0, ARST_N_IN = 0, WR_EN_IN = 0, RD_EN_IN = 0;
  logic SETUP_MODE_IN = 0, TIME_SCALE_IN = 0, RD_VALID_OUT;
  logic [4:0] ADDR_IN = 5'h00;
  logic [9:0] WR_DATA_IN = 10'h000, RD_DATA_OUT;
  logic [2:0] SETPOINT_CODE_OUT;
  logic [1:0] LINK_WATCHDOG_TIMEOUT_CODE_OUT;
  logic [3:0] DELAY_CODE_OUT, DESAT_CODE_OUT;
  logic [15:0] SETPOINT_MV_OUT;
  logic [11:0] LINK_WATCHDOG_TIMEOUT_US_OUT;
  logic [13:0] DELAY_NS_OUT, DESAT_MV_OUT;
  int n_fail = 0, n_compared = 0;
  gdcfg_regs uut (.CLOCK_IN, .ARST_N_IN, .WR_EN_IN, .RD_EN_IN, .ADDR_IN,
    .WR_DATA_IN, .SETUP_MODE_IN, .TIME_SCALE_IN, .RD_DATA_OUT, .RD_VALID_OUT,
    .SETPOINT_CODE_OUT, .LINK_WATCHDOG_TIMEOUT_CODE_OUT, .DELAY_CODE_OUT, .DESAT_CODE_OUT,
    .SETPOINT_MV_OUT, .LINK_WATCHDOG_TIMEOUT_US_OUT, .DELAY_NS_OUT, .DESAT_MV_OUT);
  always #12.5 CLOCK_IN = ~CLOCK_IN;
  // ====================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge CLOCK_IN);
    #1;
  endtask
  // One access; returns just after the edge that takes it
  task automatic acc(input logic wr, input logic [4:0] a,
    input logic [9:0] d);
    @(posedge CLOCK_IN);
    WR_EN_IN <= wr;
    RD_EN_IN <= !wr;
    ADDR_IN <= a;
    WR_DATA_IN <= d;
    @(posedge CLOCK_IN);
    WR_EN_IN <= 1'b0;
    RD_EN_IN <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [9:0] exp);
    acc(1'b0, a, 10'h000);
    // The answer stands for one cycle only, so look at it right away
    chk(RD_VALID_OUT, 16'h0001);
    chk(RD_DATA_OUT, {6'h00, exp});
  endtask
  task automatic print_verdict();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ====================
  // Scenarios
  task automatic t_reset();
    chk({SETPOINT_CODE_OUT, LINK_WATCHDOG_TIMEOUT_CODE_OUT}, 16'h0007);
    chk({DELAY_CODE_OUT, DESAT_CODE_OUT}, 16'h00AA);
    chk(SETPOINT_MV_OUT, 16'h3A98);
    chk(LINK_WATCHDOG_TIMEOUT_US_OUT, 16'h07D0);
    chk(DELAY_NS_OUT, 16'h0FA0);
    chk(DESAT_MV_OUT, 16'h1770);
    rd(5'h07, 10'h0BA);
    rd(5'h08, 10'h00A);
    $display("t_reset done");
  endtask
  // Normal operation: only the setpoint may move
  task automatic t_lock();
    acc(1'b1, 5'h07, 10'h3C5);
    chk(SETPOINT_CODE_OUT, 16'h0007);
    chk({LINK_WATCHDOG_TIMEOUT_CODE_OUT, DELAY_CODE_OUT}, 16'h003A);
    acc(1'b1, 5'h08, 10'h003);
    acc(1'b1, 5'h09, 10'h3FF);
    chk(DESAT_CODE_OUT, 16'h000A);
    rd(5'h07, 10'h3BA);
    $display("t_lock done");
  endtask
  task automatic t_sweep();
    logic [3:0] c;
    int sp, dl, ds;
    int wdt[4] = '{260, 500, 1000, 2000};
    @(posedge CLOCK_IN);
    SETUP_MODE_IN <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      sp = (c[2:0] == 0) ? 0 : 14000 + 1000 * c[2:0];
      dl = (i == 0) ? 0 : (i <= 10) ? i * 400 : (i - 5) * 800;
      ds = (i <= 12) ? 1000 + 500 * i : (i - 5) * 1000;
      acc(1'b1, 5'h07, {c[2:0], 1'b1, c[1:0], c});
      acc(1'b1, 5'h08, {6'h3F, c});
      tick();
      chk(SETPOINT_MV_OUT, 16'(sp));
      chk(LINK_WATCHDOG_TIMEOUT_US_OUT, 16'(wdt[i % 4]));
      chk(DELAY_NS_OUT, 16'(dl));
      chk(DESAT_MV_OUT, 16'(ds));
      rd(5'h07, {c[2:0], 1'b0, c[1:0], c});
      rd(5'h08, {6'h00, c});
    end
    $display("t_sweep done");
  endtask
  task automatic t_scale();
    acc(1'b1, 5'h07, 10'h003);
    @(posedge CLOCK_IN);
    TIME_SCALE_IN <= 1'b1;
    tick();
    tick();
    chk(DELAY_CODE_OUT, 16'h000A);
    chk(DELAY_NS_OUT, 16'h07D0);
    acc(1'b1, 5'h07, 10'h002);
    tick();
    chk(DELAY_NS_OUT, 16'h0190);
    @(posedge CLOCK_IN);
    TIME_SCALE_IN <= 1'b0;
    tick();
    tick();
    chk(DELAY_CODE_OUT, 16'h000A);
    chk(DELAY_NS_OUT, 16'h0FA0);
    $display("t_scale done");
  endtask
  initial begin
    repeat (10) @(posedge CLOCK_IN);
    ARST_N_IN <= 1'b1;
    tick();
    tick();
    t_reset();
    t_lock();
    t_sweep();
    t_scale();
    print_verdict();
  end
  // Tests need about 4.5 us; eleven times that means a hang
  initial begin
    #50000;
    n_fail++;
    print_verdict();
  end
endmodule
